/* design/rdsf_pkg.sv */
// shared constants and types for the rgb dither serializer front and its host
// Functional notes
// - pins stable at pixel clock rise, captured there
// - dither each 24-bit pixel down to 18 bits
// - vertical sync always driven, restarts dither pattern
// - vertical sync forwarded unaltered onto link
// - optional three 256x8 colour correction tables
// - control port only when selected, awake, clock stopped
// - shared pin is control data, output only reading
// - shared pin is horizontal sync while deselected
// - sleep while sleep_n low, run while high
// - sleep resets settings, keeps table contents
// - optional link power down on stopped pixel clock
// - frame sequence bits resync after link error
// - link uses two or three lanes plus clock
// - test select held low, test mode unused
`default_nettype none
package rdsf_pkg;
	localparam int CHANNELS = 3;
	localparam int IN_CH_BITS = 8;
	localparam int OUT_CH_BITS = 6;
	localparam int IN_BITS = CHANNELS * IN_CH_BITS;
	localparam int OUT_BITS = CHANNELS * OUT_CH_BITS;
	localparam int TBL_DEPTH = 256;
	// link word layout
	localparam int WORD_BITS = 24;
	localparam int W_MARK = 23;
	localparam int W_SEQ_LSB = 21;
	localparam int W_DE = 20;
	localparam int W_HS = 19;
	localparam int W_VS = 18;
	// control frame: read flag, 7-bit address, 8-bit data, msb first
	localparam int CTRL_BITS = 16;
	localparam int CTRL_ADDR_BITS = 7;
	localparam int CTRL_DATA_BITS = 8;
	localparam logic [6:0] A_CFG = 7'h00;
	localparam logic [6:0] A_PTR = 7'h01;
	localparam logic [6:0] A_STATUS = 7'h02;
	localparam logic [6:0] A_TBL_BASE = 7'h04;
	localparam int CFG_TBL_EN = 0;
	localparam int CFG_DITHER_EN = 1;
	localparam int CFG_AUTO_SLEEP = 2;
	localparam logic [7:0] CFG_RESET = 8'h06;
	// synchroniser bit positions in the device's own clock domain
	localparam int SY_PCLK = 0;
	localparam int SY_SEL = 1;
	localparam int SY_SCL = 2;
	localparam int SY_PIN = 3;
	localparam int SY_SLEEP = 4;
	localparam int SY_TEST = 5;
	// 2x2 ordered dither thresholds
	localparam logic [1:0] DITHER_THR [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
	// timing
	localparam int CLOCK_NS = 50;
	localparam int PCLK_STOP_NS = 2000;
	localparam int PCLK_STOP_CYC = (PCLK_STOP_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int HOST_GUARD_CYC = 4;
	localparam int HOST_STOP_CYC = PCLK_STOP_CYC + HOST_GUARD_CYC;
	typedef enum logic {SER_IDLE, SER_SHIFT} rdsf_ser_e;
	typedef enum logic [1:0] {CMD_IDLE, CMD_SEL, CMD_BITS, CMD_END} rdsf_cmd_e;
endpackage
`default_nettype wire

/* design/rdsf_if.sv */
// pins between the pixel host and the serializer front
`default_nettype none
interface rdsf_if;
	import rdsf_pkg::*;
	logic pclk;
	logic [IN_BITS-1:0] rgb;
	logic vs;
	logic de;
	logic sel_n;
	logic scl;
	logic sleep_n;
	logic test_sel;
	logic host_o;
	logic host_oe;
	logic dev_o;
	logic dev_oe;
	logic pin;
	// shared data/hsync wire, pulled high when nobody drives
	assign pin = dev_oe ? dev_o : (host_oe ? host_o : 1'b1);
	modport host (output pclk, rgb, vs, de, sel_n, scl, sleep_n, test_sel, host_o, host_oe, input pin);
	modport device (input pclk, rgb, vs, de, sel_n, scl, sleep_n, test_sel, pin, output dev_o, dev_oe);
endinterface
`default_nettype wire

/* design/rdsf_device.sv */
// serializer front: pixel capture, tables, dither, fifo, control port, link
`default_nettype none
module rdsf_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	input wire logic i_wclk,
	input wire logic i_wrst_n,
	input wire logic i_wvalid,
	input wire logic [WIDTH-1:0] i_wdata,
	output logic o_wready,
	input wire logic i_rclk,
	input wire logic i_rrst_n,
	input wire logic i_rready,
	output logic o_rvalid,
	output logic [WIDTH-1:0] o_rdata
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 4 || (1 << AW) != DEPTH)
	begin : g_bad_depth
		$error("fifo depth must be a power of two, at least 4");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wbin, wgray, rbin, rgray, wg_meta, wg_sync, rg_meta, rg_sync;
	logic [AW:0] next_wbin, next_rbin;
	assign next_wbin = wbin + (AW + 1)'(1);
	assign next_rbin = rbin + (AW + 1)'(1);
	assign o_wready = wgray != {~rg_sync[AW:AW-1], rg_sync[AW-2:0]};
	assign o_rvalid = rgray != wg_sync;
	assign o_rdata = mem[rbin[AW-1:0]];
	// write pointer, gray copy crosses to the read side
	always_ff @(posedge i_wclk)
	begin
		if (!i_wrst_n)
		begin
			wbin <= '0;
			wgray <= '0;
		end
		else if (i_wvalid && o_wready)
		begin
			wbin <= next_wbin;
			wgray <= next_wbin ^ (next_wbin >> 1);
		end
	end
	always_ff @(posedge i_wclk)
	begin
		if (i_wvalid && o_wready)
			mem[wbin[AW-1:0]] <= i_wdata;
	end
	always_ff @(posedge i_wclk)
	begin
		rg_meta <= rgray;
		rg_sync <= rg_meta;
	end
	// read pointer
	always_ff @(posedge i_rclk)
	begin
		if (!i_rrst_n)
		begin
			rbin <= '0;
			rgray <= '0;
		end
		else if (i_rready && o_rvalid)
		begin
			rbin <= next_rbin;
			rgray <= next_rbin ^ (next_rbin >> 1);
		end
	end
	always_ff @(posedge i_rclk)
	begin
		if (!i_rrst_n)
		begin
			wg_meta <= '0;
			wg_sync <= '0;
		end
		else
		begin
			wg_meta <= wgray;
			wg_sync <= wg_meta;
		end
	end
endmodule

module rdsf_device import rdsf_pkg::*; #(
	parameter int LANES = 3,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	rdsf_if.device bus,
	output logic [LANES-1:0] o_link_data_lanes,
	output logic o_link_clock_out,
	output logic o_link_active
);
	localparam int BPL = WORD_BITS / LANES;
	if (LANES < 2 || LANES > 3)
	begin : g_bad_lanes
		$error("link supports two or three data lanes");
	end
	logic [7:0] tbl [CHANNELS][TBL_DEPTH];
	logic [7:0] cfg;
	// pixel clock domain
	logic [4:0] p_meta, p_sync;
	logic p_rst_n, p_awake;
	logic prst_req, p_ack;
	logic [1:0] pack_sync;
	logic [IN_BITS-1:0] cap_rgb;
	logic cap_vs, cap_hs, cap_de, cap_vs_d, cap_hs_d, cap_de_d;
	logic frame, xpos, ypos, vs_rise, drop, err;
	logic [1:0] seq;
	logic [OUT_BITS-1:0] dith;
	logic wvalid, wready;
	logic [WORD_BITS-1:0] word;
	assign p_rst_n = p_sync[4];
	assign p_awake = p_sync[3];
	assign vs_rise = cap_vs && !cap_vs_d;
	assign drop = wvalid && !wready;
	// reset, sleep and settings levels brought into the pixel clock domain
	always_ff @(posedge bus.pclk)
	begin
		p_meta <= {!prst_req, bus.sleep_n, cfg[2:0]};
		p_sync <= p_meta;
	end
	// tells the own clock domain that the pixel logic has seen its reset
	always_ff @(posedge bus.pclk)
	begin
		p_ack <= !p_rst_n;
	end
	// pixel reset request is held until the pixel clock has run it in, so a stopped clock loses no reset
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			prst_req <= 1'b1;
			pack_sync <= 2'h0;
		end
		else
		begin
			pack_sync <= {pack_sync[0], p_ack};
			if (pack_sync[1])
				prst_req <= 1'b0;
		end
	end
	// pins sampled on the pixel clock rise; shared pin is hsync only when deselected
	always_ff @(posedge bus.pclk)
	begin
		cap_rgb <= bus.rgb;
		cap_vs <= bus.vs;
		cap_hs <= bus.sel_n & bus.pin;
		cap_de <= bus.de;
		cap_vs_d <= cap_vs;
		cap_hs_d <= cap_hs;
		cap_de_d <= cap_de;
	end
	// dither position: frame parity flips on vsync, line parity on enable fall
	always_ff @(posedge bus.pclk)
	begin
		if (!p_rst_n)
		begin
			frame <= 1'b0;
			xpos <= 1'b0;
			ypos <= 1'b0;
		end
		else if (vs_rise)
		begin
			frame <= ~frame;
			xpos <= 1'b0;
			ypos <= 1'b0;
		end
		else if (cap_de)
			xpos <= ~xpos;
		else if (cap_de_d)
		begin
			xpos <= 1'b0;
			ypos <= ~ypos;
		end
	end
	// per channel table lookup then threshold add with saturation
	for (genvar c = 0; c < CHANNELS; c++)
	begin : g_chan
		logic [7:0] raw, corr;
		logic [8:0] sum;
		assign raw = cap_rgb[c*IN_CH_BITS +: IN_CH_BITS];
		assign corr = p_sync[CFG_TBL_EN] ? tbl[c][raw] : raw;
		assign sum = {1'b0, corr} + {7'h00, p_sync[CFG_DITHER_EN] ? DITHER_THR[{ypos ^ frame, xpos}] : 2'h0};
		assign dith[c*OUT_CH_BITS +: OUT_CH_BITS] = sum[8] ? 6'h3F : sum[7:2];
	end
	// link word built for enabled pixels and for every sync change
	always_ff @(posedge bus.pclk)
	begin
		if (!p_rst_n)
			wvalid <= 1'b0;
		else
			wvalid <= p_awake && (cap_de || cap_vs != cap_vs_d || cap_hs != cap_hs_d);
		word <= {1'b1, seq, cap_de, cap_hs, cap_vs, cap_de ? dith : 18'h00000};
	end
	// sequence bits restart from zero at the frame after a dropped word
	always_ff @(posedge bus.pclk)
	begin
		if (!p_rst_n)
		begin
			seq <= 2'h0;
			err <= 1'b0;
		end
		else if (vs_rise)
		begin
			seq <= err ? 2'h0 : seq + 2'h1;
			err <= drop;
		end
		else if (drop)
			err <= 1'b1;
	end
	logic rvalid, rready, f_rrst_n;
	// read side waits until the write pointers are known
	assign f_rrst_n = i_rst_n && !prst_req;
	logic [WORD_BITS-1:0] rdata;
	rdsf_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_wclk(bus.pclk),
		.i_wrst_n(p_rst_n),
		.i_wvalid(wvalid),
		.i_wdata(word),
		.o_wready(wready),
		.i_rclk(i_clock),
		.i_rrst_n(f_rrst_n),
		.i_rready(rready),
		.o_rvalid(rvalid),
		.o_rdata(rdata)
	);
	// own clock domain: pin synchronisers
	logic [5:0] s_meta, s_sync;
	logic pclk_d, scl_d, awake, pclk_stopped, port_en, scl_rise, scl_fall, commit, dev_oe;
	logic [5:0] idle_cnt;
	logic [4:0] bit_cnt;
	logic [15:0] shin;
	logic [7:0] tx, ptr, rd_value;
	logic [6:0] rd_addr, wr_addr;
	logic [7:0] wr_data;
	rdsf_ser_e state;
	logic phase;
	logic [3:0] sbits;
	logic [WORD_BITS-1:0] shreg;
	logic link_on, auto_stop;
	always_ff @(posedge i_clock)
	begin
		s_meta <= {bus.test_sel, bus.sleep_n, bus.pin, bus.scl, bus.sel_n, bus.pclk};
		s_sync <= s_meta;
		pclk_d <= s_sync[SY_PCLK];
		scl_d <= s_sync[SY_SCL];
	end
	assign awake = s_sync[SY_SLEEP];
	assign pclk_stopped = idle_cnt == 6'(PCLK_STOP_CYC);
	assign port_en = !s_sync[SY_SEL] && awake && pclk_stopped;
	assign scl_rise = port_en && s_sync[SY_SCL] && !scl_d;
	assign scl_fall = port_en && !s_sync[SY_SCL] && scl_d;
	assign rd_addr = {shin[5:0], s_sync[SY_PIN]};
	assign wr_addr = shin[13:7];
	assign wr_data = {shin[6:0], s_sync[SY_PIN]};
	assign commit = scl_rise && bit_cnt == 5'(CTRL_BITS - 1) && !shin[14];
	// pixel clock activity watch
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n || s_sync[SY_PCLK] != pclk_d)
			idle_cnt <= 6'h00;
		else if (!pclk_stopped)
			idle_cnt <= idle_cnt + 6'h01;
	end
	// register read mux for the control port
	always_comb
	begin
		if (rd_addr[6:2] == A_TBL_BASE[6:2] && rd_addr[1:0] != 2'h3)
			rd_value = tbl[rd_addr[1:0]][ptr];
		else if (rd_addr == A_CFG)
			rd_value = cfg;
		else if (rd_addr == A_PTR)
			rd_value = ptr;
		else if (rd_addr == A_STATUS)
			rd_value = {5'h00, o_link_active, pclk_stopped, state == SER_SHIFT};
		else
			rd_value = 8'h00;
	end
	// control port shifter; pin turns to output for read data, at the fall after the address once the host let go
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n || !port_en)
		begin
			bit_cnt <= 5'h00;
			dev_oe <= 1'b0;
		end
		else if (scl_rise)
		begin
			shin <= {shin[14:0], s_sync[SY_PIN]};
			bit_cnt <= bit_cnt + 5'h01;
			if (bit_cnt == 5'(CTRL_ADDR_BITS) && shin[6])
				tx <= rd_value;
			else if (bit_cnt > 5'(CTRL_ADDR_BITS))
				tx <= {tx[6:0], 1'b0};
		end
		else if (scl_fall && bit_cnt == 5'(CTRL_ADDR_BITS + 1) && shin[CTRL_ADDR_BITS])
			dev_oe <= 1'b1;
	end
	assign bus.dev_o = tx[7];
	assign bus.dev_oe = dev_oe;
	// settings return to defaults in sleep
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n || !awake)
		begin
			cfg <= CFG_RESET;
			ptr <= 8'h00;
		end
		else if (commit)
		begin
			if (wr_addr == A_CFG)
				cfg <= wr_data;
			else if (wr_addr == A_PTR)
				ptr <= wr_data;
			else if (wr_addr[6:2] == A_TBL_BASE[6:2] && wr_addr[1:0] != 2'h3)
				ptr <= ptr + 8'h01;
		end
	end
	// table store has no reset so contents survive sleep
	always_ff @(posedge i_clock)
	begin
		if (commit && wr_addr[6:2] == A_TBL_BASE[6:2] && wr_addr[1:0] != 2'h3)
			tbl[wr_addr[1:0]][ptr] <= wr_data;
	end
	// link serializer: data moves on clock fall, receiver samples on rise
	assign link_on = awake && !s_sync[SY_TEST];
	assign auto_stop = cfg[CFG_AUTO_SLEEP] && pclk_stopped;
	assign rready = state == SER_IDLE && link_on;
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			state <= SER_IDLE;
			phase <= 1'b0;
			sbits <= 4'h0;
			shreg <= '0;
			o_link_active <= 1'b0;
		end
		else
		begin
			unique case (state)
				SER_IDLE:
				begin
					phase <= 1'b0;
					sbits <= 4'h0;
					o_link_active <= link_on && (rvalid || !auto_stop);
					if (link_on && (rvalid || !auto_stop))
					begin
						shreg <= rvalid ? rdata : '0;
						state <= SER_SHIFT;
					end
					else
						shreg <= '0;
				end
				SER_SHIFT:
				begin
					phase <= link_on && !phase;
					// sleep or test select cuts the word short
					if (!link_on)
					begin
						state <= SER_IDLE;
						o_link_active <= 1'b0;
					end
					else if (phase)
					begin
						shreg <= shreg << 1;
						sbits <= sbits + 4'h1;
						if (sbits == 4'(BPL - 1))
							state <= SER_IDLE;
					end
				end
			endcase
		end
	end
	assign o_link_clock_out = phase;
	for (genvar l = 0; l < LANES; l++)
	begin : g_lane
		assign o_link_data_lanes[l] = shreg[l*BPL + BPL - 1];
	end
endmodule
`default_nettype wire

/* design/rdsf_host.sv */
// pixel host: pixel clock divider, pixel launch and control port master
`default_nettype none
module rdsf_host import rdsf_pkg::*; #(
	parameter int PCLK_HALF = 10,
	parameter int SCL_HALF = 8
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	rdsf_if.host bus,
	input wire logic [IN_BITS-1:0] i_pix_rgb,
	input wire logic i_pix_vs,
	input wire logic i_pix_hs,
	input wire logic i_pix_de,
	output logic o_pix_take,
	input wire logic i_pclk_run,
	input wire logic i_sleep_n,
	input wire logic i_cmd_valid,
	input wire logic i_cmd_read,
	input wire logic [CTRL_ADDR_BITS-1:0] i_cmd_addr,
	input wire logic [CTRL_DATA_BITS-1:0] i_cmd_wdata,
	output logic o_cmd_ready,
	output logic o_rsp_valid,
	output logic [CTRL_DATA_BITS-1:0] o_rsp_data
);
	if (PCLK_HALF < 2 || PCLK_HALF > 255 || SCL_HALF < 6 || SCL_HALF > 255)
	begin : g_bad_div
		$error("pixel half period 2..255, control half period 6..255");
	end
	rdsf_cmd_e state;
	logic [7:0] div_cnt, cnt;
	logic [6:0] stop_cnt;
	logic pclk, sleep_reg, hs_reg, rd, pin_meta, pin_sync;
	logic [3:0] bitn;
	logic [CTRL_BITS-1:0] frame;
	assign o_pix_take = div_cnt == 8'(PCLK_HALF - 1) && pclk;
	assign o_cmd_ready = state == CMD_IDLE && sleep_reg && !pclk && !i_pclk_run
		&& stop_cnt == 7'(HOST_STOP_CYC);
	// pixel clock divider; it finishes its high half and rests low
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			div_cnt <= 8'h00;
			pclk <= 1'b0;
		end
		else if (div_cnt == 8'(PCLK_HALF - 1))
		begin
			div_cnt <= 8'h00;
			if (pclk || (i_pclk_run && state == CMD_IDLE))
				pclk <= ~pclk;
		end
		else
			div_cnt <= div_cnt + 8'h01;
	end
	// pins launched on the falling edge, stable across the next rise
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			bus.rgb <= '0;
			bus.vs <= 1'b0;
			bus.de <= 1'b0;
			hs_reg <= 1'b0;
		end
		else if (o_pix_take)
		begin
			bus.rgb <= i_pix_rgb;
			bus.vs <= i_pix_vs;
			bus.de <= i_pix_de;
			hs_reg <= i_pix_hs;
		end
	end
	// how long the pixel clock has rested, and sleep pin and pin sampling
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n || pclk || i_pclk_run)
			stop_cnt <= 7'h00;
		else if (stop_cnt != 7'(HOST_STOP_CYC))
			stop_cnt <= stop_cnt + 7'h01;
		sleep_reg <= i_rst_n && i_sleep_n;
		pin_meta <= bus.pin;
		pin_sync <= pin_meta;
	end
	// control transfer: select, sixteen clocks msb first, deselect, guard
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			state <= CMD_IDLE;
			bus.sel_n <= 1'b1;
			bus.scl <= 1'b0;
			cnt <= 8'h00;
			bitn <= 4'h0;
			rd <= 1'b0;
			frame <= '0;
			o_rsp_valid <= 1'b0;
			o_rsp_data <= 8'h00;
		end
		else
		begin
			o_rsp_valid <= 1'b0;
			unique case (state)
				CMD_IDLE:
				begin
					cnt <= 8'h00;
					bitn <= 4'h0;
					if (i_cmd_valid && o_cmd_ready)
					begin
						frame <= {i_cmd_read, i_cmd_addr, i_cmd_wdata};
						rd <= i_cmd_read;
						bus.sel_n <= 1'b0;
						state <= CMD_SEL;
					end
				end
				CMD_SEL:
				begin
					cnt <= cnt + 8'h01;
					if (cnt == 8'(SCL_HALF - 1))
					begin
						cnt <= 8'h00;
						bus.scl <= 1'b1;
						state <= CMD_BITS;
					end
				end
				CMD_BITS:
				begin
					cnt <= cnt + 8'h01;
					if (cnt == 8'(SCL_HALF - 1))
					begin
						cnt <= 8'h00;
						if (bus.scl)
						begin
							bus.scl <= 1'b0;
							frame <= frame << 1;
							bitn <= bitn + 4'h1;
							if (bitn == 4'(CTRL_BITS - 1))
							begin
								bus.sel_n <= 1'b1;
								state <= CMD_END;
							end
						end
						else
						begin
							bus.scl <= 1'b1;
							if (bitn >= 4'(CTRL_ADDR_BITS + 1))
								o_rsp_data <= {o_rsp_data[6:0], pin_sync};
						end
					end
				end
				CMD_END:
				begin
					cnt <= cnt + 8'h01;
					if (cnt == 8'(HOST_GUARD_CYC - 1))
					begin
						o_rsp_valid <= 1'b1;
						state <= CMD_IDLE;
					end
				end
			endcase
		end
	end
	// shared pin: hsync while idle, released for read data bits and the guard
	always_comb
	begin
		bus.host_oe = 1'b0;
		bus.host_o = frame[CTRL_BITS-1];
		unique case (state)
			CMD_IDLE:
			begin
				bus.host_oe = 1'b1;
				bus.host_o = hs_reg;
			end
			CMD_SEL:
				bus.host_oe = 1'b1;
			CMD_BITS:
				bus.host_oe = !rd || bitn <= 4'(CTRL_ADDR_BITS);
			CMD_END:
				bus.host_oe = 1'b0;
		endcase
	end
	assign bus.pclk = pclk;
	assign bus.sleep_n = sleep_reg;
	assign bus.test_sel = 1'b0;
endmodule
`default_nettype wire

/* test/rdsf_sva.sv */
// concurrent checks on the host-device pins and the link outputs
`default_nettype none
module rdsf_sva #(
	parameter int LANES = 3
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic pclk,
	input wire logic sel_n,
	input wire logic sleep_n,
	input wire logic test_sel,
	input wire logic host_oe,
	input wire logic dev_oe,
	input wire logic [LANES-1:0] o_link_data_lanes,
	input wire logic o_link_clock_out,
	input wire logic o_link_active
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	// ownership of the shared data/hsync pin
	a_pin_is_hsync: assert property (sel_n [*5] |-> !dev_oe)
		else $error("device drives shared pin while deselected");
	a_no_contention: assert property (dev_oe |-> !host_oe)
		else $error("host and device drive shared pin together");
	// control port only with a stopped pixel clock and an awake device; link off in sleep, test select held low
	a_pclk_static: assert property (!sel_n |-> $stable(pclk))
		else $error("pixel clock moves during a control transfer");
	a_sleep_port_off: assert property (!sleep_n [*5] |-> !dev_oe)
		else $error("control port answers while asleep");
	a_sleep_link_off: assert property (!sleep_n [*5] |-> !o_link_active)
		else $error("link active while asleep");
	a_test_held_low: assert property (!test_sel)
		else $error("test select raised");
	// link clock shape and data timing
	a_lane_hold: assert property ($rose(o_link_clock_out) |-> $stable(o_link_data_lanes))
		else $error("lane data changed on link clock rise");
	a_clock_half: assert property ($rose(o_link_clock_out) |=> $fell(o_link_clock_out))
		else $error("link clock high longer than one cycle");
	a_clock_in_word: assert property (o_link_clock_out |-> o_link_active)
		else $error("link clock toggles while link idle");
	// main scenarios reached
	c_read_drive: cover property ($rose(dev_oe));
	c_link_start: cover property ($rose(o_link_active));
	c_sleep: cover property ($fell(sleep_n));
endmodule
`default_nettype wire

/* test/rgb_dither_serializer_front_bench.sv */
// self-checking bench: host and device joined, control and pixel traffic
`default_nettype none
module rgb_dither_serializer_front_bench import rdsf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 1'h0, i_rst_n = 1'h0, pix_vs = 1'h0, pix_hs = 1'h0, pix_de = 1'h0, pclk_run = 1'h0;
	logic sleep_n = 1'h0, cmd_valid = 1'h0, cmd_read = 1'h0, pix_take, cmd_ready, rsp_valid, lclk, lact;
	logic lclk_d = 1'h0;
	logic [IN_BITS-1:0] pix_rgb = '0;
	logic [CTRL_ADDR_BITS-1:0] cmd_addr = '0;
	logic [CTRL_DATA_BITS-1:0] cmd_wdata = '0, rsp_data, tx;
	logic [2:0] lanes;
	logic [WORD_BITS-1:0] word = '0;
	logic [8:0] rd_q[$];
	logic [20:0] px_q[$];
	logic [7:0] tbl [3];
	int errors = 0, checked = 0, seed = 37, nbit = 0, mode = 0;
	rdsf_if bus();
	rdsf_host rdsf_host_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .bus(bus), .i_pix_rgb(pix_rgb), .i_pix_vs(pix_vs),
		.i_pix_hs(pix_hs), .i_pix_de(pix_de), .o_pix_take(pix_take), .i_pclk_run(pclk_run), .i_sleep_n(sleep_n),
		.i_cmd_valid(cmd_valid), .i_cmd_read(cmd_read), .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata),
		.o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data));
	rdsf_device #(.LANES(3), .FIFO_DEPTH(32)) rdsf_device_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .bus(bus),
		.o_link_data_lanes(lanes), .o_link_clock_out(lclk), .o_link_active(lact));
	rdsf_sva #(.LANES(3)) rdsf_sva_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .pclk(bus.pclk), .sel_n(bus.sel_n),
		.sleep_n(bus.sleep_n), .test_sel(bus.test_sel), .host_oe(bus.host_oe), .dev_oe(bus.dev_oe),
		.o_link_data_lanes(lanes), .o_link_clock_out(lclk), .o_link_active(lact));
	// clock
	initial
	begin
		forever #25 i_clock = ~i_clock;
	end
	task automatic fail(input string what, input logic [23:0] exp, input logic [23:0] got);
		errors++;
		$display("[FAIL] %s expected %h seen %h", what, exp, got);
	endtask
	task automatic summarize;
		if (errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic guard(input int n, input int lim);
		if (n >= lim)
		begin
			fail("wait bound", 24'h0, 24'h0);
			summarize();
		end
	endtask
	task automatic cmp_rsp(input logic [8:0] note);
		checked++;
		if (note[8] && rsp_data !== note[7:0])
			fail("read data", {16'h0, note[7:0]}, {16'h0, rsp_data});
	endtask
	task automatic cmp_word;
		logic [20:0] e;
		e = (px_q.size() > 0) ? px_q.pop_front() : 21'h1FFFFF;
		checked++;
		if (word[20:0] !== e)
			fail("link word", {3'h0, e}, word);
	endtask
	// one control transfer; d is write data or the expected read value
	task automatic cmd(input logic rd, input logic [6:0] a, input logic [7:0] d);
		int n;
		cmd_valid <= 1'h1;
		cmd_read <= rd;
		cmd_addr <= a;
		cmd_wdata <= d;
		rd_q.push_back({rd, d});
		n = 0;
		do @(posedge i_clock); while (cmd_ready !== 1'h1 && ++n < 2000);
		guard(n, 2000);
		cmd_valid <= 1'h0;
		n = 0;
		do @(posedge i_clock); while (cmd_ready !== 1'h1 && ++n < 2000);
		guard(n, 2000);
	endtask
	function automatic logic [20:0] expect_px();
		logic [23:0] c;
		c = (mode == 2) ? {tbl[2], tbl[1], tbl[0]} : pix_rgb;
		return {pix_de, pix_hs, pix_vs, c[23:18], c[15:10], c[7:2]};
	endfunction
	// a run of pixels: mode 0 plain, 1 dither with exact values, 2 tables; blank first while the pixel side settles
	task automatic pixels(input int m, input logic [7:0] cfg);
		int n, k;
		logic [31:0] r;
		cmd(1'h0, A_CFG, cfg);
		mode = m;
		pclk_run <= 1'h1;
		n = 0;
		for (k = 0; k < 3000 && n < 60; k++)
		begin
			@(posedge i_clock);
			if (pix_take === 1'h1)
			begin
				if (pix_de)
					px_q.push_back(expect_px());
				n++;
				r = $random(seed);
				pix_de <= (n > 8) && (n < 50) && r[24];
				if ((n > 8) && (n < 50) && r[24])
				begin
					pix_vs <= r[25];
					pix_hs <= r[26];
				end
				pix_rgb <= (m == 2) ? {3{tx}} : ((m == 1) ? (r[23:0] & 24'hFCFCFC) : r[23:0]);
			end
		end
		guard(k, 3000);
		pclk_run <= 1'h0;
		for (k = 0; k < 3000 && px_q.size() > 0; k++)
			@(posedge i_clock);
		guard(k, 3000);
	endtask
	// read answers are checked against the oldest note
	always @(posedge i_clock)
	begin
		if (rsp_valid === 1'h1)
			cmp_rsp((rd_q.size() > 0) ? rd_q.pop_front() : 9'h1FF);
	end
	// rebuild link words at each link clock rise, lane l carries bits l*8+7 first
	always @(posedge i_clock)
	begin
		lclk_d <= lclk;
		if (!i_rst_n || lact !== 1'h1)
			nbit = 0;
		else if (lclk === 1'h1 && lclk_d === 1'h0)
		begin
			for (int l = 0; l < 3; l++)
				word[l*8+7-nbit] = lanes[l];
			nbit = (nbit + 1) % 8;
			if (nbit == 0 && word[W_MARK] === 1'h1)
				cmp_word();
		end
	end
	// main sequence
	initial
	begin
		int n;
		repeat (8) @(posedge i_clock);
		i_rst_n <= 1'h1;
		sleep_n <= 1'h1;
		cmd(1'h1, A_CFG, CFG_RESET);
		cmd(1'h1, 7'h03, 8'h00);
		tx = 8'($random(seed));
		for (int c = 0; c < 3; c++)
		begin
			tbl[c] = 8'($random(seed));
			cmd(1'h0, A_PTR, tx);
			cmd(1'h0, A_TBL_BASE + 7'(c), tbl[c]);
			cmd(1'h1, A_PTR, tx + 8'h01);
			cmd(1'h0, A_PTR, tx);
			cmd(1'h1, A_TBL_BASE + 7'(c), tbl[c]);
		end
		cmd(1'h1, A_PTR, tx);
		cmd(1'h0, A_CFG, 8'h00);
		sleep_n <= 1'h0;
		repeat (20) @(posedge i_clock);
		sleep_n <= 1'h1;
		cmd(1'h1, A_CFG, CFG_RESET);
		cmd(1'h1, A_PTR, 8'h00);
		cmd(1'h1, A_STATUS, 8'h02);
		cmd(1'h0, A_PTR, tx);
		cmd(1'h1, A_TBL_BASE + 7'h02, tbl[2]);
		pixels(0, 8'h00);
		pixels(1, 8'h02);
		pixels(2, 8'h01);
		for (n = 0; n < 500 && rd_q.size() > 0; n++)
			@(posedge i_clock);
		guard(n, 500);
		summarize();
	end
	// hang cutter
	initial
	begin
		#5000000;
		fail("watchdog", 24'h0, 24'h0);
		summarize();
	end
endmodule
`default_nettype wire
